// ==== hw/mabp_pkg.sv ====
// Constants and types for the multiplexed address/data bus port.
// Assumes one clock domain and AHB-Lite register access.
`default_nettype none
package mabp_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_ADDR = 8'h04;
   localparam logic [7:0] OFF_WDATA = 8'h08;
   localparam logic [7:0] OFF_CMD = 8'h0c;
   localparam logic [7:0] OFF_RDATA = 8'h10;
   localparam logic [7:0] OFF_STATUS = 8'h14;
   // Control field positions and reset value
   localparam int CTRL_INHIBIT = 0;
   localparam int CTRL_WIDTH_LSB = 1;
   localparam int CTRL_BIG = 3;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // Command field positions
   localparam int CMD_WRITE = 0;
   localparam int CMD_QUAD = 1;
   localparam int CMD_SIZE_LSB = 2;
   localparam int CMD_INSTR = 4;
   localparam int CMD_MISS = 5;
   // Status field positions
   localparam int ST_BUSY = 0;
   localparam int ST_AVAIL = 1;
   localparam int ST_OPT_LSB = 2;
   localparam int ST_COUNT_LSB = 6;
   // Port width and datum size encodings
   localparam logic [1:0] PW_32 = 2'h0;
   localparam logic [1:0] PW_16 = 2'h1;
   localparam logic [1:0] PW_8 = 2'h2;
   localparam logic [1:0] SZ_BYTE = 2'h0;
   localparam logic [1:0] SZ_HALF = 2'h1;
   localparam logic [1:0] SZ_WORD = 2'h2;
   // Reset option bits sampled on the low address pins
   localparam int OPT_BOOT16 = 0;
   localparam int OPT_BOOT8 = 1;
   localparam int OPT_RSVD_HIGH = 2;
   localparam int OPT_EXT_HOLD = 3;
   localparam logic [4:0] QUAD_BYTES = 5'h10;

   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic write;
      logic quad;
      logic [1:0] size;
      logic instr;
      logic miss;
   } mabp_req_t;

   typedef struct packed {
      logic inhibit;
      logic [1:0] width;
      logic big;
   } mabp_cfg_t;

   typedef enum logic [2:0] {S_IDLE, S_ADDR, S_HOLD, S_DATA, S_PUSH} mabp_state_t;
endpackage
`default_nettype wire

// ==== hw/mabp_port.sv ====
// Multiplexed address/data bus port with AHB-Lite control registers.
// Assumes synchronous pin inputs; the far side acks each data beat.
//
// Overview of operation
// [R1] Address phase on shared pins, latched by strobe
// [R2] Upper address bits on shared pins 31:4
// [R3] Active-low byte-lane strobes on pins 3:0
// [R4] Outside ignores strobes for narrow ports
// [R5] Strobes held inactive on reads when configured
// [R6] Shared pins carry data after address
// [R7] Writes drive data from write entry
// [R8] Single or four-word reads into buffer
// [R9] Lanes from size, port width, ordering
// [R10] Memory decodes low bits per port width
// [R11] Exact low address, stepped while wider
// [R12] Quad reads count low address from zero
// [R13] Low address pins sampled at reset
// [R14] Diagnostic pin multiplexed across read cycles
// [R15] Data slot: high instruction, low data
// [R16] Address slot: diag shows cache miss
// [R17] Extended hold keeps address extra time
// [R18] One latch strobe per transaction
`default_nettype none
module mabp_port (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Shared address/data pins
   input wire logic [31:0] ad_in,
   output logic [31:0] ad_out,
   output logic ad_oe,
   // Low address pins
   input wire logic [3:0] low_addr_in,
   output logic [3:0] low_addr_out,
   output logic low_addr_oe,
   // Transfer control
   output logic ale,
   output logic rd_strobe,
   output logic wr_strobe,
   input wire logic mem_ack,
   output logic diag
);
   // AHB address phase capture
   logic ph_valid_reg, ph_valid_next;
   logic ph_write_reg, ph_write_next;
   logic [7:0] ph_addr_reg, ph_addr_next;
   logic rd_pop;

   always_comb begin
      ph_valid_next = ph_valid_reg;
      ph_write_next = ph_write_reg;
      ph_addr_next = ph_addr_reg;
      if (hready) begin
         ph_valid_next = hsel & htrans[1];
         ph_write_next = hwrite;
         ph_addr_next = haddr[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_valid_reg <= 1'b0;
         ph_write_reg <= 1'b0;
         ph_addr_reg <= 8'h00;
      end else begin
         ph_valid_reg <= ph_valid_next;
         ph_write_reg <= ph_write_next;
         ph_addr_reg <= ph_addr_next;
      end
   end

   // Zero-wait slave, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // Software registers
   mabp_pkg::mabp_cfg_t cfg_reg, cfg_next;
   mabp_pkg::mabp_req_t pend_reg, pend_next;
   logic go_reg, go_next;
   logic busy;
   logic wr_hit;

   assign wr_hit = ph_valid_reg & ph_write_reg;

   always_comb begin
      cfg_next = cfg_reg;
      pend_next = pend_reg;
      go_next = 1'b0;
      if (wr_hit) begin
         case (ph_addr_reg)
            mabp_pkg::OFF_CTRL: begin
               cfg_next.inhibit = hwdata[mabp_pkg::CTRL_INHIBIT];
               cfg_next.width = hwdata[mabp_pkg::CTRL_WIDTH_LSB +: 2];
               cfg_next.big = hwdata[mabp_pkg::CTRL_BIG];
            end
            mabp_pkg::OFF_ADDR: pend_next.addr = hwdata;
            mabp_pkg::OFF_WDATA: pend_next.wdata = hwdata;
            mabp_pkg::OFF_CMD: begin
               // Commands while busy are dropped so a running transfer's command never changes
               if (!busy && !go_reg) begin
                  pend_next.write = hwdata[mabp_pkg::CMD_WRITE];
                  pend_next.quad = hwdata[mabp_pkg::CMD_QUAD] & ~hwdata[mabp_pkg::CMD_WRITE];
                  pend_next.size = hwdata[mabp_pkg::CMD_SIZE_LSB +: 2];
                  pend_next.instr = hwdata[mabp_pkg::CMD_INSTR];
                  pend_next.miss = hwdata[mabp_pkg::CMD_MISS];
                  go_next = 1'b1;
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_reg <= mabp_pkg::mabp_cfg_t'(mabp_pkg::CTRL_RESET[3:0]);
         pend_reg <= '0;
         go_reg <= 1'b0;
      end else begin
         cfg_reg <= cfg_next;
         pend_reg <= pend_next;
         go_reg <= go_next;
      end
   end

   // [R13] Reset option capture
   logic first_reg, first_next;
   logic [3:0] opt_reg, opt_next;

   always_comb begin
      first_next = 1'b0;
      opt_next = opt_reg;
      if (first_reg) begin
         opt_next = low_addr_in;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         first_reg <= 1'b1;
         opt_reg <= 4'h0;
      end else begin
         first_reg <= first_next;
         opt_reg <= opt_next;
      end
   end

   // Two-entry read buffer
   logic [31:0] buf_mem [2];
   logic buf_wp_reg, buf_wp_next, buf_rp_reg, buf_rp_next;
   logic [1:0] buf_cnt_reg, buf_cnt_next;
   logic buf_in_valid, buf_in_ready, buf_out_valid;
   logic [31:0] buf_in_data;

   assign buf_in_ready = (buf_cnt_reg != 2'h2);
   assign buf_out_valid = (buf_cnt_reg != 2'h0);
   assign rd_pop = ph_valid_reg & ~ph_write_reg & (ph_addr_reg == mabp_pkg::OFF_RDATA);

   always_comb begin
      buf_wp_next = buf_wp_reg;
      buf_rp_next = buf_rp_reg;
      buf_cnt_next = buf_cnt_reg;
      if (buf_in_valid && buf_in_ready) begin
         buf_wp_next = ~buf_wp_reg;
      end
      if (rd_pop && buf_out_valid) begin
         buf_rp_next = ~buf_rp_reg;
      end
      buf_cnt_next = buf_cnt_reg + {1'b0, buf_in_valid & buf_in_ready}
         - {1'b0, rd_pop & buf_out_valid};
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         buf_wp_reg <= 1'b0;
         buf_rp_reg <= 1'b0;
         buf_cnt_reg <= 2'h0;
         buf_mem[0] <= 32'h0000_0000;
         buf_mem[1] <= 32'h0000_0000;
      end else begin
         buf_wp_reg <= buf_wp_next;
         buf_rp_reg <= buf_rp_next;
         buf_cnt_reg <= buf_cnt_next;
         if (buf_in_valid && buf_in_ready) begin
            buf_mem[buf_wp_reg] <= buf_in_data;
         end
      end
   end

   // Read-back mux
   always_comb begin
      hrdata = 32'h0000_0000;
      if (ph_valid_reg && !ph_write_reg) begin
         case (ph_addr_reg)
            mabp_pkg::OFF_CTRL: hrdata = {28'h0, cfg_reg.big, cfg_reg.width, cfg_reg.inhibit};
            mabp_pkg::OFF_ADDR: hrdata = pend_reg.addr;
            mabp_pkg::OFF_WDATA: hrdata = pend_reg.wdata;
            mabp_pkg::OFF_RDATA: hrdata = buf_out_valid ? buf_mem[buf_rp_reg] : 32'h0000_0000;
            mabp_pkg::OFF_STATUS: hrdata = {24'h0, buf_cnt_reg, opt_reg, buf_out_valid, busy};
            default: hrdata = 32'h0000_0000;
         endcase
      end
   end

   // Transfer engine
   mabp_pkg::mabp_state_t st_reg, st_next;
   mabp_pkg::mabp_req_t cur_reg, cur_next;
   logic [3:0] low_reg, low_next;
   logic [4:0] left_reg, left_next;
   logic [31:0] word_reg, word_next;
   logic [4:0] pb, beat;
   logic [4:0] off8;
   logic [31:0] lmask, tmask;
   logic [3:0] lanes;
   logic word_done;

   assign busy = (st_reg != mabp_pkg::S_IDLE);
   // [R9] Lane offset within the word, aligned to the port
   assign pb = (cfg_reg.width == mabp_pkg::PW_32) ? 5'h04 :
               (cfg_reg.width == mabp_pkg::PW_16) ? 5'h02 : 5'h01;
   // Only the address bits at or above the port's own width move the lanes; the bits below it are masked off
   assign off8 = {(low_reg[1:0] & ~(pb[1:0] - 2'h1)), 3'h0};
   assign lmask = (pb == 5'h04) ? 32'hffff_ffff : (pb == 5'h02) ? 32'h0000_ffff : 32'h0000_00ff;
   assign tmask = (pb == 5'h04) ? 32'hffff_ffff : (pb == 5'h02) ? 32'hffff_0000 : 32'hff00_0000;
   assign beat = (pb < left_reg) ? pb : left_reg;

   always_comb begin
      st_next = st_reg;
      cur_next = cur_reg;
      low_next = low_reg;
      left_next = left_reg;
      word_next = word_reg;
      word_done = 1'b0;
      buf_in_valid = 1'b0;
      case (st_reg)
         mabp_pkg::S_IDLE: begin
            if (go_reg) begin
               cur_next = pend_reg;
               // [R11] [R12] Start at exact address or zero
               low_next = pend_reg.quad ? 4'h0 : pend_reg.addr[3:0];
               left_next = pend_reg.quad ? mabp_pkg::QUAD_BYTES : (5'h01 << pend_reg.size);
               st_next = mabp_pkg::S_ADDR;
            end
         end
         mabp_pkg::S_ADDR: begin
            // [R17] Extra hold cycle after the strobe falls
            st_next = opt_reg[mabp_pkg::OPT_EXT_HOLD] ? mabp_pkg::S_HOLD : mabp_pkg::S_DATA;
         end
         mabp_pkg::S_HOLD: st_next = mabp_pkg::S_DATA;
         mabp_pkg::S_DATA: begin
            if (mem_ack) begin
               // [R8] [R9] Pack the returned lanes into the word
               if (cfg_reg.big) begin
                  word_next = (word_reg & ~(tmask >> off8)) | ((ad_in & tmask) >> off8);
               end else begin
                  word_next = (word_reg & ~(lmask << off8)) | ((ad_in & lmask) << off8);
               end
               // [R11] [R12] Step by the port width
               left_next = left_reg - beat;
               low_next = low_reg + pb[3:0];
               word_done = ~cur_reg.write & (cur_reg.quad ? (low_next[1:0] == 2'h0) || (pb == 5'h04)
                  : (left_next == 5'h00));
               if (word_done) begin
                  st_next = mabp_pkg::S_PUSH;
               end else if (left_next == 5'h00) begin
                  st_next = mabp_pkg::S_IDLE;
               end
            end
         end
         mabp_pkg::S_PUSH: begin
            // A full buffer holds the engine here, so no word is lost
            buf_in_valid = 1'b1;
            if (buf_in_ready) begin
               st_next = (left_reg == 5'h00) ? mabp_pkg::S_IDLE : mabp_pkg::S_DATA;
            end
         end
         default: st_next = mabp_pkg::S_IDLE;
      endcase
   end

   assign buf_in_data = word_reg;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg <= mabp_pkg::S_IDLE;
         cur_reg <= '0;
         low_reg <= 4'h0;
         left_reg <= 5'h00;
         word_reg <= 32'h0000_0000;
      end else begin
         st_reg <= st_next;
         cur_reg <= cur_next;
         low_reg <= low_next;
         left_reg <= left_next;
         word_reg <= word_next;
      end
   end

   // Pin outputs decoded from registered state only
   logic addr_ph;
   assign addr_ph = (st_reg == mabp_pkg::S_ADDR) || (st_reg == mabp_pkg::S_HOLD);

   // [R3] [R9] Byte lanes of the datum, reversed for big-endian
   always_comb begin
      lanes = ((cur_reg.size == mabp_pkg::SZ_WORD) ? 4'hf :
               (cur_reg.size == mabp_pkg::SZ_HALF) ? 4'h3 : 4'h1) << cur_reg.addr[1:0];
      if (cfg_reg.big) begin
         lanes = {lanes[0], lanes[1], lanes[2], lanes[3]};
      end
      // [R5] Reads may keep every strobe inactive
      if (cfg_reg.inhibit && !cur_reg.write) begin
         lanes = 4'h0;
      end
   end

   always_comb begin
      ad_out = 32'h0000_0000;
      if (addr_ph) begin
         // [R1] [R2] [R3] Address and active-low strobes
         ad_out = {cur_reg.addr[31:4], ~lanes};
      end else if (cur_reg.write) begin
         // [R6] [R7] Write entry data on the shared pins
         ad_out = cfg_reg.big ? (cur_reg.wdata << off8) : (cur_reg.wdata >> off8);
      end
   end

   // [R6] Pins released for read data
   assign ad_oe = addr_ph || ((st_reg == mabp_pkg::S_DATA) && cur_reg.write);
   // [R18] Strobe only in the first address cycle
   assign ale = (st_reg == mabp_pkg::S_ADDR);
   assign rd_strobe = (st_reg == mabp_pkg::S_DATA) && !cur_reg.write;
   assign wr_strobe = (st_reg == mabp_pkg::S_DATA) && cur_reg.write;
   // [R13] Pins are inputs until options are caught
   assign low_addr_oe = ~first_reg;
   assign low_addr_out = low_reg;
   // [R14] [R15] [R16] Miss in address slot, type in data slot
   assign diag = addr_ph ? cur_reg.miss : cur_reg.instr;

   // Checks
   property p_ale_once;
      @(posedge hclk) disable iff (!hresetn) ale |=> !ale until (st_reg == mabp_pkg::S_IDLE);
   endproperty
   a_ale_once: assert property (p_ale_once) else $error("second latch strobe"); // [R18]

   property p_ale_before_data;
      @(posedge hclk) disable iff (!hresetn)
         $rose(rd_strobe || wr_strobe) |->
            $past(ale, 1) || $past(ale, 2) || ($past(st_reg) == mabp_pkg::S_PUSH);
   endproperty
   a_ale_before_data: assert property (p_ale_before_data) else $error("data without address"); // [R1]

   property p_upper_addr;
      @(posedge hclk) disable iff (!hresetn) ale |-> ad_oe && ad_out[31:4] == cur_reg.addr[31:4];
   endproperty
   a_upper_addr: assert property (p_upper_addr) else $error("upper address wrong"); // [R2]

   property p_read_inhibit;
      @(posedge hclk) disable iff (!hresetn)
         ale && cfg_reg.inhibit && !cur_reg.write |-> ad_out[3:0] == 4'hf;
   endproperty
   a_read_inhibit: assert property (p_read_inhibit) else $error("strobe active on read"); // [R5]

   property p_word_strobes;
      @(posedge hclk) disable iff (!hresetn)
         ale && cur_reg.write && cur_reg.size == mabp_pkg::SZ_WORD |-> ad_out[3:0] == 4'h0;
   endproperty
   a_word_strobes: assert property (p_word_strobes) else $error("word strobes wrong"); // [R3]

   property p_read_release;
      @(posedge hclk) disable iff (!hresetn) rd_strobe |-> !ad_oe;
   endproperty
   a_read_release: assert property (p_read_release) else $error("pins driven on read"); // [R6]

   property p_write_data;
      @(posedge hclk) disable iff (!hresetn)
         wr_strobe && cfg_reg.width == mabp_pkg::PW_32 |-> ad_oe && ad_out == cur_reg.wdata;
   endproperty
   a_write_data: assert property (p_write_data) else $error("write data wrong"); // [R7]

   property p_quad_start;
      @(posedge hclk) disable iff (!hresetn) ale && cur_reg.quad |-> low_addr_out == 4'h0;
   endproperty
   a_quad_start: assert property (p_quad_start) else $error("quad not from zero"); // [R12]

   property p_low_step;
      @(posedge hclk) disable iff (!hresetn)
         (st_reg == mabp_pkg::S_DATA) && mem_ack |=> low_addr_out == $past(low_addr_out) + pb[3:0];
   endproperty
   a_low_step: assert property (p_low_step) else $error("low address step wrong"); // [R11]

   property p_ext_hold;
      @(posedge hclk) disable iff (!hresetn)
         ale && opt_reg[mabp_pkg::OPT_EXT_HOLD] |=> !ale && ad_oe && ad_out == $past(ad_out);
   endproperty
   a_ext_hold: assert property (p_ext_hold) else $error("address not held"); // [R17]

   property p_diag_slots;
      @(posedge hclk) disable iff (!hresetn)
         (ale |-> diag == cur_reg.miss) and (rd_strobe |-> diag == cur_reg.instr);
   endproperty
   a_diag_slots: assert property (p_diag_slots) else $error("diag slot wrong"); // [R16]

   property p_push_stall;
      @(posedge hclk) disable iff (!hresetn)
         buf_in_valid && !buf_in_ready |=> st_reg == mabp_pkg::S_PUSH && buf_cnt_reg != 2'h0;
   endproperty
   a_push_stall: assert property (p_push_stall) else $error("word lost on full buffer"); // [R8]
endmodule
`default_nettype wire

// ==== sim/mabp_mem.sv ====
// Memory-side model of the shared address/data bus.
// Assumes the port's pin order: one ale cycle, then a strobe held per beat.
`default_nettype none
module mabp_mem (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Pins from the port
   input wire logic [31:0] ad_out,
   input wire logic [3:0] low_addr_out,
   input wire logic ale,
   input wire logic rd_strobe,
   input wire logic wr_strobe,
   input wire logic diag,
   // Pins to the port
   output logic [31:0] ad_in,
   output logic mem_ack,
   // Bench control
   input wire logic slow
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] wait_cnt;
   logic [31:0] addr_word, hold_word;
   logic diag_a, diag_d, hold_ale, after_ale;
   int n_ale = 0;
   logic [3:0] la_q[$];
   logic [31:0] wd_q[$];

   // Read data keyed by low address, inverted once released
   assign ad_in = rd_strobe ? {8{low_addr_out}} : ~{8{low_addr_out}};

   // Address word latched on ale, lanes left undecoded
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mem_ack <= 1'b0;
         wait_cnt <= 3'h0;
         after_ale <= 1'b0;
      end else begin
         after_ale <= ale;
         if (ale) begin
            n_ale <= n_ale + 1;
            addr_word <= ad_out;
            diag_a <= diag;
         end
         if (after_ale) begin
            hold_word <= ad_out;
            hold_ale <= ale;
         end
         // Slow mode stalls each beat to exercise the level strobe
         if (mem_ack) begin
            mem_ack <= 1'b0;
            if (rd_strobe | wr_strobe) begin
               la_q.push_back(low_addr_out);
               wd_q.push_back(ad_out);
               diag_d <= diag;
            end
         end else if (rd_strobe | wr_strobe) begin
            if (wait_cnt >= (slow ? 3'h3 : 3'h0)) begin
               mem_ack <= 1'b1;
               wait_cnt <= 3'h0;
            end else begin
               wait_cnt <= wait_cnt + 3'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== sim/tb_muxed_addr_data_bus_port.sv ====
// Self-checking bench for the multiplexed address/data bus port.
// Assumes mabp_mem on the pins and a zero-wait register bus.
`default_nettype none
module tb_muxed_addr_data_bus_port;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
   $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, slow = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [3:0] opts = 4'h0;
   wire logic hreadyout, hresp, ad_oe, low_addr_oe, ale, rd_strobe, wr_strobe, mem_ack, diag;
   wire logic [31:0] hrdata, ad_in, ad_out;
   wire logic [3:0] low_addr_out, low_addr_in;
   int n_errors = 0, compares = 0;

   // Options reach the pins only while the port is not driving them
   assign low_addr_in = low_addr_oe ? low_addr_out : opts;

   mabp_port i_mabp_port (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ad_in(ad_in), .ad_out(ad_out),
      .ad_oe(ad_oe), .low_addr_in(low_addr_in), .low_addr_out(low_addr_out),
      .low_addr_oe(low_addr_oe), .ale(ale), .rd_strobe(rd_strobe), .wr_strobe(wr_strobe),
      .mem_ack(mem_ack), .diag(diag));
   mabp_mem i_mabp_mem (.hclk(hclk), .hresetn(hresetn), .ad_out(ad_out),
      .low_addr_out(low_addr_out), .ale(ale), .rd_strobe(rd_strobe), .wr_strobe(wr_strobe),
      .diag(diag), .ad_in(ad_in), .mem_ack(mem_ack), .slow(slow));

   initial forever #2.5 hclk = ~hclk;

   task automatic wrap_up();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic edge_rdy();
      for (int i = 0; i < 50; i++) begin
         @(posedge hclk);
         if (hreadyout === 1'b1)
            return;
      end
      n_errors++;
      wrap_up();
   endtask

   // One single transfer; read data lands in rd
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      edge_rdy();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      edge_rdy();
      rd = hrdata;
   endtask

   task automatic poll(input logic [31:0] m, input logic [31:0] v);
      for (int i = 0; i < 100; i++) begin
         bus(1'b0, mabp_pkg::OFF_STATUS, 32'h0);
         if ((rd & m) === v)
            return;
      end
      n_errors++;
      wrap_up();
   endtask

   task automatic go(input logic [5:0] c, input logic idle);
      i_mabp_mem.la_q.delete();
      i_mabp_mem.wd_q.delete();
      bus(1'b1, mabp_pkg::OFF_CMD, {26'h0, c});
      bus(1'b0, mabp_pkg::OFF_STATUS, 32'h0);
      if (idle)
         poll(32'h1, 32'h0);
   endtask

   task automatic do_reset(input logic [3:0] o);
      opts <= o;
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      bus(1'b0, mabp_pkg::OFF_STATUS, 32'h0);
      `CHK(rd[mabp_pkg::ST_OPT_LSB +: 4], o)
   endtask

   task automatic t_wr_word();
      int n;
      bus(1'b1, mabp_pkg::OFF_CTRL, 32'h0);
      bus(1'b1, mabp_pkg::OFF_ADDR, 32'h1234_5678);
      bus(1'b1, mabp_pkg::OFF_WDATA, 32'hcafe_0123);
      n = i_mabp_mem.n_ale;
      go(6'h09, 1'b1);
      `CHK(i_mabp_mem.n_ale, n + 1)
      `CHK(i_mabp_mem.addr_word, 32'h1234_5670)
      `CHK(i_mabp_mem.hold_word, 32'hcafe_0123)
      `CHK(i_mabp_mem.la_q.size(), 1)
      `CHK(i_mabp_mem.la_q[0], 4'h8)
      `CHK(i_mabp_mem.wd_q[0], 32'hcafe_0123)
      bus(1'b0, 8'h18, 32'h0);
      `CHK(rd, 32'h0)
   endtask

   // Byte at offset 1, half at offset 2, in both orderings
   task automatic t_lanes();
      logic [3:0] e[4] = '{4'hd, 4'hb, 4'h3, 4'hc};
      for (int k = 0; k < 4; k++) begin
         bus(1'b1, mabp_pkg::OFF_CTRL, {28'h0, k[0], 3'h0});
         bus(1'b1, mabp_pkg::OFF_ADDR, k < 2 ? 32'h41 : 32'h42);
         go(k < 2 ? 6'h01 : 6'h05, 1'b1);
         `CHK(i_mabp_mem.addr_word[3:0], e[k])
      end
   endtask

   task automatic t_rd();
      for (int j = 0; j < 2; j++) begin
         bus(1'b1, mabp_pkg::OFF_CTRL, {31'h0, j[0]});
         bus(1'b1, mabp_pkg::OFF_ADDR, 32'h1008);
         go(j ? 6'h38 : 6'h08, 1'b1);
         `CHK(i_mabp_mem.addr_word[3:0], j ? 4'hf : 4'h0)
         `CHK(i_mabp_mem.diag_a, j[0])
         `CHK(i_mabp_mem.diag_d, j[0])
         bus(1'b0, mabp_pkg::OFF_RDATA, 32'h0);
         `CHK(rd, 32'h8888_8888)
      end
   endtask

   // Quad read on a 16-bit port, memory slow, buffer left full a while
   task automatic t_quad16();
      logic [3:0] a;
      slow <= 1'b1;
      bus(1'b1, mabp_pkg::OFF_CTRL, 32'h2);
      bus(1'b1, mabp_pkg::OFF_ADDR, 32'h2004);
      go(6'h0a, 1'b0);
      poll(32'hc1, 32'h81);
      repeat (20) @(posedge hclk);
      `CHK(i_mabp_mem.la_q.size(), 6)
      for (int k = 0; k < 4; k++) begin
         poll(32'h2, 32'h2);
         bus(1'b0, mabp_pkg::OFF_RDATA, 32'h0);
         a = 4'(4 * k);
         `CHK(rd, {{4{a + 4'h2}}, {4{a}}})
      end
      poll(32'h3, 32'h0);
      for (int k = 0; k < 8; k++)
         `CHK(i_mabp_mem.la_q[k], 4'(2 * k))
      slow <= 1'b0;
   endtask

   task automatic t_wr8();
      bus(1'b1, mabp_pkg::OFF_CTRL, 32'h4);
      bus(1'b1, mabp_pkg::OFF_ADDR, 32'h3004);
      bus(1'b1, mabp_pkg::OFF_WDATA, 32'h4433_2211);
      go(6'h09, 1'b1);
      `CHK(i_mabp_mem.la_q.size(), 4)
      for (int k = 0; k < 4; k++) begin
         `CHK(i_mabp_mem.la_q[k], 4'(4 + k))
         `CHK(i_mabp_mem.wd_q[k][7:0], 8'(8'h11 * (k + 1)))
      end
   endtask

   // Quad read on an 8-bit big-endian port, popped word by word
   task automatic t_quad8();
      logic [3:0] a;
      bus(1'b1, mabp_pkg::OFF_CTRL, 32'hc);
      bus(1'b1, mabp_pkg::OFF_ADDR, 32'h600c);
      go(6'h0a, 1'b0);
      for (int k = 0; k < 4; k++) begin
         poll(32'h2, 32'h2);
         bus(1'b0, mabp_pkg::OFF_RDATA, 32'h0);
         a = 4'(4 * k);
         `CHK(rd, {{2{a}}, {2{a + 4'h1}}, {2{a + 4'h2}}, {2{a + 4'h3}}})
      end
      poll(32'h3, 32'h0);
      `CHK(i_mabp_mem.la_q.size(), 16)
      `CHK(i_mabp_mem.la_q[15], 4'hf)
   endtask

   task automatic t_hold();
      do_reset(4'h8);
      bus(1'b1, mabp_pkg::OFF_CTRL, 32'h0);
      bus(1'b1, mabp_pkg::OFF_ADDR, 32'h5670);
      go(6'h09, 1'b1);
      `CHK(i_mabp_mem.hold_word, i_mabp_mem.addr_word)
      `CHK(i_mabp_mem.hold_ale, 1'b0)
   endtask

   initial begin
      do_reset(4'h5);
      t_wr_word();
      t_lanes();
      t_rd();
      t_quad16();
      t_wr8();
      t_quad8();
      t_hold();
      wrap_up();
   end
`undef CHK
endmodule
`default_nettype wire
